// *** opsc_chk.sv ***
// Port-level checker for the oscillator power-save block
`timescale 1ns/1ps
`default_nettype none
module opsc_chk
  import opsc_pkg::*;
(
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       waitInstr,
  input wire logic       wakeIrqValid,
  input wire logic [2:0] wakeIrqPriority,
  input wire logic [2:0] cpuPriority,
  input wire logic       watchdogTimeout,
  input wire logic       cpuHalted,
  input wire logic       sleepActive,
  input wire logic       idleActive,
  input wire logic       failsafeMonitorRun,
  input wire logic [2:0] activeSource,
  input wire logic [8:0] pllOutputDivide,
  input wire logic [4:0] pllMultiplyFactor,
  input wire logic [8:0] fastRcDivide
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rstn);

  AST_PLL_DIV: assert property (pllOutputDivide inside {1, 2, 4, 8, 16, 32, 64, 256})
    else $error("pll output divide is not a legal ratio");
  AST_FRC_DIV: assert property (fastRcDivide inside {1, 2, 4, 8, 16, 32, 64, 256})
    else $error("fast rc divide is not a legal ratio");
  AST_PLL_MULT: assert property (pllMultiplyFactor inside {[15:21], 24})
    else $error("pll multiply factor is not a legal value");
  AST_WAIT_HALT: assert property (waitInstr && !cpuHalted
    |=> cpuHalted && (sleepActive ^ idleActive))
    else $error("wait did not halt into exactly one mode");
  AST_WDOG_WAKE: assert property (sleepActive && watchdogTimeout
    |=> !sleepActive && !cpuHalted)
    else $error("watchdog timeout did not wake from sleep");
  AST_IRQ_WAKE: assert property (cpuHalted && wakeIrqValid
    && (wakeIrqPriority > cpuPriority) |=> !cpuHalted)
    else $error("higher priority interrupt did not wake the cpu");
  AST_LOW_IRQ: assert property (sleepActive && wakeIrqValid && !watchdogTimeout
    && (wakeIrqPriority <= cpuPriority) |=> idleActive && cpuHalted)
    else $error("low priority interrupt did not move sleep to idle");
  AST_NO_MON_SLEEP: assert property (sleepActive |-> !failsafeMonitorRun)
    else $error("fail-safe monitor runs in sleep");
  AST_SRC_KEPT: assert property (sleepActive |=> activeSource == $past(activeSource))
    else $error("active source changed across sleep");
  AST_B_TIMING: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response not two cycles after address and data");
  AST_R_TIMING: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not one cycle after address");

  cover property ($rose(sleepActive));
  cover property ($rose(idleActive));
  cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule
bind opsc_top opsc_chk i_chk (.clk, .rstn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .waitInstr, .wakeIrqValid, .wakeIrqPriority, .cpuPriority, .watchdogTimeout, .cpuHalted,
  .sleepActive, .idleActive, .failsafeMonitorRun, .activeSource, .pllOutputDivide,
  .pllMultiplyFactor, .fastRcDivide);
`default_nettype wire

// *** opsc_pkg.sv ***
// Package of offsets, field positions and reset values for the oscillator power-save block
package opsc_pkg;
  localparam logic [7:0] OSC_CTRL_ADDR      = 8'h00;
  localparam logic [7:0] OSC_CLR_ADDR       = 8'h04;
  localparam logic [7:0] OSC_SET_ADDR       = 8'h08;
  localparam logic [7:0] OSC_INV_ADDR       = 8'h0C;
  localparam logic [7:0] WDOG_CTRL_ADDR     = 8'h10;
  localparam logic [7:0] WDOG_CLR_ADDR      = 8'h14;
  localparam logic [7:0] WDOG_SET_ADDR      = 8'h18;
  localparam logic [7:0] WDOG_INV_ADDR      = 8'h1C;
  localparam logic [7:0] RST_CAUSE_ADDR     = 8'h20;
  localparam logic [7:0] RST_CLR_ADDR       = 8'h24;
  localparam logic [7:0] RST_SET_ADDR       = 8'h28;
  localparam logic [7:0] RST_INV_ADDR       = 8'h2C;

  localparam int PLL_ODIV_LSB   = 27;
  localparam int FRC_DIV_LSB    = 24;
  localparam int SECONDARY_OSCILLATOR_RDY_BIT   = 22;
  localparam int PB_DIV_LSB     = 19;
  localparam int PLL_MULT_LSB   = 16;
  localparam int CUR_SRC_LSB    = 12;
  localparam int NEW_SRC_LSB    = 8;
  localparam int FREEZE_BIT     = 7;
  localparam int USB_LOCK_BIT   = 6;
  localparam int PLL_LOCK_BIT   = 5;
  localparam int DEEP_HALT_BIT  = 4;
  localparam int CLK_FAIL_BIT   = 3;
  localparam int USB_FRC_BIT    = 2;
  localparam int SECONDARY_OSCILLATOR_EN_BIT    = 1;
  localparam int SWITCH_REQ_BIT = 0;
  localparam int WDOG_ON_BIT    = 15;
  localparam int WAKE_SLEEP_BIT = 3;
  localparam int WAKE_IDLE_BIT  = 2;

  // Bits software may write in each register
  localparam logic [31:0] OSC_WMASK   = 32'h3F1F079F;
  localparam logic [31:0] OSC_LOCKED  = 32'h3F1F0701;
  localparam logic [31:0] WDOG_WMASK  = 32'h00008001;
  localparam logic [31:0] RST_WMASK   = 32'h000003DF;
  localparam logic [2:0]  FRC_DIV_RST = 3'h1;
  localparam logic [2:0]  SRC_PLL_FRC = 3'h1;
  localparam logic [2:0]  SRC_PLL_PRI = 3'h3;
  localparam logic [2:0]  SRC_SEC     = 3'h4;
  localparam logic [2:0]  SRC_LOW_POWER_INTERNAL_RC    = 3'h5;
  localparam logic [7:0]  SWITCH_CYCLES = 8'h08;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {PWR_RUN, PWR_IDLE, PWR_SLEEP} opsc_pwr_e;
endpackage

// *** opsc_top.sv ***
// Oscillator selection and power-save control with AXI4-Lite registers
//
// The register offsets and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - PLL output divider bits 29:27, 111 is 256
// - Reset loads fields from configuration inputs
// - Fast RC divider bits 26:24, default divide 2
// - Secondary ready bit 22 tracks stable oscillator
// - Bus divisor bits 20:19 divide 1,2,4,8
// - PLL multiplier bits 18:16, 15..21 then 24
// - Current source read-only at bits 14:12
// - New source selection at bits 10:8
// - Switch request bit 0 clears when done
// - Freeze bit blocks selection changes under monitor
// - USB PLL lock status bit 6
// - System PLL lock status bit 5
// - Wait enters SLEEP if bit 4 else IDLE
// - Clock-fail flag bit 3 set on failure
// - Bit 2 picks USB clock source
// - Bit 1 enables secondary oscillator
// - Watchdog on keeps low-power RC in SLEEP
// - Wake from SLEEP sets cause bit 3
// - Wake from IDLE sets cause bit 2
// - Reset, timeout or higher interrupt leaves SLEEP
// - Low-priority wake goes to IDLE, bus clock restarts
// - Watchdog not cleared; monitor suspended in SLEEP
// - Clear, set, invert companion registers
// - Wake resumes on source active at entry
module opsc_top
  import opsc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [2:0]  cfgPllOutputDivider,
  input  wire logic [2:0]  cfgPllMultiplier,
  input  wire logic [1:0]  cfgBusDivisor,
  input  wire logic [2:0]  cfgInitialSource,
  input  wire logic        cfgSecondaryOscEnable,
  input  wire logic        failsafeMonitorConfig,
  input  wire logic        secondaryOscStable,
  input  wire logic        pllLocked,
  input  wire logic        usbPllLocked,
  input  wire logic        clockFailDetect,
  input  wire logic        waitInstr,
  input  wire logic        wakeIrqValid,
  input  wire logic [2:0]  wakeIrqPriority,
  input  wire logic [2:0]  cpuPriority,
  input  wire logic        watchdogTimeout,
  output logic             cpuHalted,
  output logic             sleepActive,
  output logic             idleActive,
  output logic             peripheralBusClockEn,
  output logic             lowPowerRcEnable,
  output logic             secondaryOscEnable,
  output logic             usbInternalRcSelect,
  output logic             failsafeMonitorRun,
  output logic [2:0]       activeSource,
  output logic [8:0]       pllOutputDivide,
  output logic [4:0]       pllMultiplyFactor,
  output logic [8:0]       fastRcDivide
);
  logic        rstSync1;
  logic        rstSync2;
  logic [31:0] oscCtrl;
  logic        wdogOn;
  logic        wdogService;
  logic [9:0]  rstCause;
  opsc_pwr_e   pwrState;
  logic [7:0]  switchCount;
  logic [2:0]  pbCount;
  logic        awHeld;
  logic        wHeld;
  logic [7:0]  awAddr;
  logic [31:0] wData;
  logic [3:0]  wStrb;
  logic        wrFire;
  logic        wrHit;
  logic [31:0] byteMask;
  logic [2:0]  pbDivMask;
  logic        wakeSleepEvt;
  logic        wakeIdleEvt;
  logic        selFrozen;
  logic        switchDone;
  logic        initDone;

  // Eight-step divide ratio shared by PLL output and fast RC dividers
  function automatic logic [8:0] div_ratio(input logic [2:0] code);
    div_ratio = (code == 3'h7) ? 9'h100 : (9'h001 << code);
  endfunction

  // Clear, set, invert or plain write of the written bits
  function automatic logic [31:0] apply_op(input logic [31:0] old, input logic [31:0] d,
                                           input logic [31:0] m, input logic [1:0] op);
    logic [31:0] r;
    r = old;
    unique case (op)
      2'h0: r = (old & ~m) | (d & m);
      2'h1: r = old & ~(d & m);
      2'h2: r = old | (d & m);
      2'h3: r = old ^ (d & m);
    endcase
    apply_op = r;
  endfunction

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rstSync1 <= 1'b0;
      rstSync2 <= 1'b0;
    end else begin
      rstSync1 <= 1'b1;
      rstSync2 <= rstSync1;
    end
  end

  // AXI write address/data capture, taken in either order
  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready  = !wHeld && !s_axi_bvalid;
  assign wrFire        = awHeld && wHeld && !s_axi_bvalid;

  always_ff @(posedge clk or negedge rstSync2) begin
    if (!rstSync2) begin
      awHeld <= 1'b0;
      awAddr <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeld <= 1'b1;
      awAddr <= s_axi_awaddr;
    end else if (wrFire) begin
      awHeld <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstSync2) begin
    if (!rstSync2) begin
      wHeld <= 1'b0;
      wData <= 32'h00000000;
      wStrb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeld <= 1'b1;
      wData <= s_axi_wdata;
      wStrb <= s_axi_wstrb;
    end else if (wrFire) begin
      wHeld <= 1'b0;
    end
  end

  always_comb begin
    byteMask = {{8{wStrb[3]}}, {8{wStrb[2]}}, {8{wStrb[1]}}, {8{wStrb[0]}}};
    wrHit    = (awAddr[7:6] == 2'h0) && (awAddr[5:0] < 6'h30) && (awAddr[1:0] == 2'h0);
  end

  always_ff @(posedge clk or negedge rstSync2) begin
    if (!rstSync2) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wrFire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wrHit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  assign selFrozen  = failsafeMonitorConfig && oscCtrl[FREEZE_BIT];
  // Switch completes only in RUN so the source seen at SLEEP entry is kept
  assign switchDone = oscCtrl[SWITCH_REQ_BIT] && (switchCount == SWITCH_CYCLES) &&
                      (pwrState == PWR_RUN);

  // Oscillator control register; reset seeds selections from configuration
  always_ff @(posedge clk or negedge rstSync2) begin
    if (!rstSync2) begin
      oscCtrl <= '0;
      oscCtrl[FRC_DIV_LSB +: 3] <= FRC_DIV_RST;
      oscCtrl[PB_DIV_LSB +: 2]  <= 2'h3;
      oscCtrl[SWITCH_REQ_BIT]   <= 1'b1;
    end else begin
      logic [31:0] nxt;
      logic [31:0] m;
      nxt = oscCtrl;
      m   = byteMask & (selFrozen ? (OSC_WMASK & ~OSC_LOCKED) : OSC_WMASK);
      // Unmapped or unaligned writes change nothing
      if (wrFire && wrHit && awAddr[7:4] == 4'h0)
        nxt = apply_op(oscCtrl, wData, m, awAddr[3:2]);
      if (switchDone) begin
        nxt[CUR_SRC_LSB +: 3] = oscCtrl[NEW_SRC_LSB +: 3];
        nxt[SWITCH_REQ_BIT]   = 1'b0;
      end
      if (clockFailDetect && failsafeMonitorRun)
        nxt[CLK_FAIL_BIT] = 1'b1;
      nxt[SECONDARY_OSCILLATOR_RDY_BIT] = oscCtrl[SECONDARY_OSCILLATOR_EN_BIT] && secondaryOscStable;
      nxt[PLL_LOCK_BIT] = pllLocked;
      nxt[USB_LOCK_BIT] = usbPllLocked;
      if (!initDone) begin
        nxt[PLL_ODIV_LSB +: 3] = cfgPllOutputDivider;
        nxt[PLL_MULT_LSB +: 3] = cfgPllMultiplier;
        nxt[PB_DIV_LSB +: 2]   = cfgBusDivisor;
        nxt[CUR_SRC_LSB +: 3]  = cfgInitialSource;
        nxt[NEW_SRC_LSB +: 3]  = cfgInitialSource;
        nxt[SECONDARY_OSCILLATOR_EN_BIT]       = cfgSecondaryOscEnable;
        nxt[SWITCH_REQ_BIT]    = 1'b0;
      end
      oscCtrl <= nxt;
    end
  end

  // Configuration straps are caught on the first clock after reset release
  always_ff @(posedge clk or negedge rstSync2) begin
    if (!rstSync2)
      initDone <= 1'b0;
    else
      initDone <= 1'b1;
  end

  // Switch settle counter stands in for the analog changeover time
  always_ff @(posedge clk or negedge rstSync2) begin
    if (!rstSync2)
      switchCount <= 8'h00;
    else if (!oscCtrl[SWITCH_REQ_BIT] || switchDone || !initDone)
      switchCount <= 8'h00;
    else if (pwrState == PWR_RUN)
      switchCount <= switchCount + 8'h01;
  end

  // Watchdog control: on bit and service bit; the service bit clears on every cycle without a watchdog write
  always_ff @(posedge clk or negedge rstSync2) begin
    if (!rstSync2) begin
      wdogOn      <= 1'b0;
      wdogService <= 1'b0;
    end else if (wrFire && wrHit && awAddr[7:4] == 4'h1) begin
      logic [31:0] w;
      w = apply_op({16'h0000, wdogOn, 14'h0000, wdogService}, wData,
                   byteMask & WDOG_WMASK, awAddr[3:2]);
      wdogOn      <= w[WDOG_ON_BIT];
      wdogService <= w[0];
    end else begin
      wdogService <= 1'b0;
    end
  end

  // Power state: wait entry, wake by reset, timeout or interrupt
  always_ff @(posedge clk or negedge rstSync2) begin
    if (!rstSync2) begin
      pwrState <= PWR_RUN;
    end else begin
      unique case (pwrState)
        PWR_RUN: begin
          if (waitInstr)
            pwrState <= oscCtrl[DEEP_HALT_BIT] ? PWR_SLEEP : PWR_IDLE;
        end
        PWR_IDLE: begin
          if (wakeIdleEvt)
            pwrState <= PWR_RUN;
        end
        PWR_SLEEP: begin
          if (wakeSleepEvt)
            pwrState <= PWR_RUN;
          else if (wakeIrqValid)
            pwrState <= PWR_IDLE;
        end
        default: pwrState <= PWR_RUN;
      endcase
    end
  end

  assign wakeSleepEvt = (pwrState == PWR_SLEEP) &&
                        (watchdogTimeout || (wakeIrqValid && wakeIrqPriority > cpuPriority));
  assign wakeIdleEvt  = (pwrState == PWR_IDLE) &&
                        (watchdogTimeout || (wakeIrqValid && wakeIrqPriority > cpuPriority));

  // Reset-cause flags; a wake event wins over a software clear in the same cycle
  always_ff @(posedge clk or negedge rstSync2) begin
    if (!rstSync2) begin
      rstCause <= 10'h000;
    end else begin
      logic [31:0] r;
      r = {22'h000000, rstCause};
      if (wrFire && wrHit && awAddr[7:4] == 4'h2)
        r = apply_op(r, wData, byteMask & RST_WMASK, awAddr[3:2]);
      if (wakeSleepEvt)
        r[WAKE_SLEEP_BIT] = 1'b1;
      if (wakeIdleEvt)
        r[WAKE_IDLE_BIT] = 1'b1;
      if (wakeSleepEvt && watchdogTimeout)
        r[4] = 1'b1;
      rstCause <= r[9:0];
    end
  end

  // Read channel
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk or negedge rstSync2) begin
    if (!rstSync2) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      unique case (s_axi_araddr)
        OSC_CTRL_ADDR:  s_axi_rdata <= oscCtrl;
        WDOG_CTRL_ADDR: s_axi_rdata <= {16'h0000, wdogOn, 15'h0000};
        RST_CAUSE_ADDR: s_axi_rdata <= {22'h000000, rstCause};
        OSC_CLR_ADDR, OSC_SET_ADDR, OSC_INV_ADDR, WDOG_CLR_ADDR, WDOG_SET_ADDR,
        WDOG_INV_ADDR, RST_CLR_ADDR, RST_SET_ADDR, RST_INV_ADDR:
          s_axi_rdata <= 32'h00000000;
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Bus clock enable divider: divide by 1, 2, 4 or 8
  always_comb begin
    unique case (oscCtrl[PB_DIV_LSB +: 2])
      2'h0: pbDivMask = 3'h0;
      2'h1: pbDivMask = 3'h1;
      2'h2: pbDivMask = 3'h3;
      2'h3: pbDivMask = 3'h7;
    endcase
  end

  always_ff @(posedge clk or negedge rstSync2) begin
    if (!rstSync2)
      pbCount <= 3'h0;
    else if (pwrState == PWR_SLEEP)
      pbCount <= 3'h0;
    else
      pbCount <= (pbCount + 3'h1) & pbDivMask;
  end

  // Outputs
  assign cpuHalted            = (pwrState != PWR_RUN);
  assign sleepActive          = (pwrState == PWR_SLEEP);
  assign idleActive           = (pwrState == PWR_IDLE);
  assign peripheralBusClockEn = (pwrState != PWR_SLEEP) && (pbCount == 3'h0);
  assign lowPowerRcEnable     = (pwrState != PWR_SLEEP) || wdogOn ||
                                (oscCtrl[CUR_SRC_LSB +: 3] == SRC_LOW_POWER_INTERNAL_RC);
  assign secondaryOscEnable   = oscCtrl[SECONDARY_OSCILLATOR_EN_BIT];
  assign usbInternalRcSelect  = oscCtrl[USB_FRC_BIT];
  assign failsafeMonitorRun   = failsafeMonitorConfig && (pwrState != PWR_SLEEP);
  assign activeSource         = oscCtrl[CUR_SRC_LSB +: 3];
  assign pllOutputDivide      = div_ratio(oscCtrl[PLL_ODIV_LSB +: 3]);
  assign fastRcDivide         = div_ratio(oscCtrl[FRC_DIV_LSB +: 3]);
  assign pllMultiplyFactor    = (oscCtrl[PLL_MULT_LSB +: 3] == 3'h7) ? 5'd24 :
                                5'(5'd15 + oscCtrl[PLL_MULT_LSB +: 3]);
endmodule
`default_nettype wire

// *** tb_opsc_top.sv ***
// Register and power-state testbench for the oscillator power-save block
`timescale 1ns/1ps
`default_nettype none
module tb_opsc_top
  import opsc_pkg::*;
;
  logic clk = 1'b0, rstn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [2:0] cfgPllOutputDivider = 3'h7, cfgPllMultiplier = 3'h7, cfgInitialSource = 3'h2;
  logic [1:0] cfgBusDivisor = 2'h2;
  logic cfgSecondaryOscEnable = 1'b1, failsafeMonitorConfig = 1'b0;
  logic secondaryOscStable = 1'b1, pllLocked = 1'b1, usbPllLocked = 1'b1;
  logic clockFailDetect = 1'b0, waitInstr = 1'b0, wakeIrqValid = 1'b0, watchdogTimeout = 1'b0;
  logic [2:0] wakeIrqPriority = 3'h0, cpuPriority = 3'h0, activeSource;
  logic cpuHalted, sleepActive, idleActive, peripheralBusClockEn, lowPowerRcEnable;
  logic secondaryOscEnable, usbInternalRcSelect, failsafeMonitorRun;
  logic [8:0] pllOutputDivide, fastRcDivide;
  logic [4:0] pllMultiplyFactor;
  int bad_count = 0;
  int cmp_count = 0;

  always #25 clk = ~clk;

  opsc_top i_dut (.clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .cfgPllOutputDivider, .cfgPllMultiplier, .cfgBusDivisor, .cfgInitialSource,
    .cfgSecondaryOscEnable, .failsafeMonitorConfig, .secondaryOscStable, .pllLocked,
    .usbPllLocked, .clockFailDetect, .waitInstr, .wakeIrqValid, .wakeIrqPriority, .cpuPriority,
    .watchdogTimeout, .cpuHalted, .sleepActive, .idleActive, .peripheralBusClockEn,
    .lowPowerRcEnable, .secondaryOscEnable, .usbInternalRcSelect, .failsafeMonitorRun,
    .activeSource, .pllOutputDivide, .pllMultiplyFactor, .fastRcDivide);

  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // Handshakes are judged at the settled half cycle before each rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    logic ta, tw, tb;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge clk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) break;
    end
    s_axi_bready <= 1'b0;
    if (n == 50) begin
      bad_count++;
      results();
    end
    @(negedge clk);
  endtask

  task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic ta, tv;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge clk);
      ta = s_axi_arvalid && s_axi_arready;
      tv = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tv) break;
    end
    s_axi_rready <= 1'b0;
    if (n == 50) begin
      bad_count++;
      results();
    end
    @(negedge clk);
  endtask

  task automatic w(input logic [7:0] a, input logic [31:0] d);
    wr(a, d, rsp);
    chk(rsp, RESP_OKAY);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rdr(a, rd, rsp);
    chk(rsp, RESP_OKAY);
    chk(rd & m, e);
  endtask

  // One-cycle event: 0 wait, 1 watchdog timeout, 2 clock failure
  task automatic pulse(input int k);
    @(posedge clk);
    if (k == 0) waitInstr <= 1'b1;
    else if (k == 1) watchdogTimeout <= 1'b1;
    else clockFailDetect <= 1'b1;
    @(posedge clk);
    waitInstr <= 1'b0;
    watchdogTimeout <= 1'b0;
    clockFailDetect <= 1'b0;
    @(negedge clk);
  endtask

  task automatic tick();
    @(posedge clk);
    @(negedge clk);
  endtask

  // First pass syncs to a pulse, second measures the full spacing
  task automatic gap(input int e);
    int c;
    repeat (2) begin
      c = 0;
      do begin
        @(negedge clk);
        c++;
      end while (!peripheralBusClockEn && c < 20);
    end
    chk(c, e);
  endtask

  initial begin
    int n;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    @(negedge clk);
    rchk(OSC_CTRL_ADDR, 32'hFFFFFFFF, 32'h39572262);
    chk(pllOutputDivide, 9'h100);
    chk(pllMultiplyFactor, 5'h18);
    chk(fastRcDivide, 9'h002);
    chk(activeSource, 3'h2);
    chk(secondaryOscEnable, 1'b1);
    @(posedge clk);
    secondaryOscStable <= 1'b0;
    pllLocked <= 1'b0;
    usbPllLocked <= 1'b0;
    rchk(OSC_CTRL_ADDR, 32'h00400060, 32'h0);
    @(posedge clk);
    secondaryOscStable <= 1'b1;
    pllLocked <= 1'b1;
    usbPllLocked <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      w(OSC_CLR_ADDR, 32'h3F070000);
      w(OSC_SET_ADDR, (i << 27) | (i << 24) | (i << 16));
      chk(pllOutputDivide, (i == 7) ? 256 : (1 << i));
      chk(fastRcDivide, (i == 7) ? 256 : (1 << i));
      chk(pllMultiplyFactor, (i == 7) ? 24 : 15 + i);
    end
    rchk(OSC_CTRL_ADDR, 32'h3F077700, 32'h3F072200);
    rchk(OSC_SET_ADDR, 32'hFFFFFFFF, 32'h0);
    w(OSC_INV_ADDR, 32'h09000000);
    chk(pllOutputDivide, 9'h040);
    for (int d = 0; d < 4; d++) begin
      w(OSC_CLR_ADDR, 32'h00180000);
      w(OSC_SET_ADDR, d << 19);
      gap(1 << d);
    end
    w(OSC_CLR_ADDR, 32'h00000700);
    w(OSC_SET_ADDR, 32'h00000400);
    w(OSC_SET_ADDR, 32'h00000001);
    for (n = 0; n < 10; n++) begin
      rdr(OSC_CTRL_ADDR, rd, rsp);
      if (rd[0] === 1'b0) break;
    end
    chk(rd[0], 1'b0);
    chk(rd[14:12], 3'h4);
    chk(activeSource, 3'h4);
    @(posedge clk);
    failsafeMonitorConfig <= 1'b1;
    w(OSC_SET_ADDR, 32'h00000080);
    w(OSC_CLR_ADDR, 32'h00000700);
    rchk(OSC_CTRL_ADDR, 32'h00000780, 32'h00000480);
    pulse(2);
    rchk(OSC_CTRL_ADDR, 32'h00000008, 32'h00000008);
    @(posedge clk);
    failsafeMonitorConfig <= 1'b0;
    w(OSC_CLR_ADDR, 32'h00000700);
    rchk(OSC_CTRL_ADDR, 32'h00000700, 32'h0);
    w(OSC_SET_ADDR, 32'h00000004);
    w(OSC_CLR_ADDR, 32'h00000002);
    chk(usbInternalRcSelect, 1'b1);
    chk(secondaryOscEnable, 1'b0);
    w(WDOG_SET_ADDR, 32'h00008000);
    rchk(WDOG_CTRL_ADDR, 32'h00008000, 32'h00008000);
    w(OSC_SET_ADDR, 32'h00000010);
    pulse(0);
    chk(sleepActive, 1'b1);
    chk(lowPowerRcEnable, 1'b1);
    chk(failsafeMonitorRun, 1'b0);
    w(WDOG_CLR_ADDR, 32'h00008000);
    chk(lowPowerRcEnable, 1'b0);
    pulse(1);
    chk(cpuHalted, 1'b0);
    chk(activeSource, 3'h4);
    rchk(RST_CAUSE_ADDR, 32'h8, 32'h8);
    w(RST_CLR_ADDR, 32'h00000008);
    rchk(RST_CAUSE_ADDR, 32'h8, 32'h0);
    pulse(0);
    @(posedge clk);
    wakeIrqPriority <= 3'h2;
    cpuPriority <= 3'h3;
    wakeIrqValid <= 1'b1;
    tick();
    chk({idleActive, cpuHalted}, 2'h3);
    gap(8);
    @(posedge clk);
    wakeIrqPriority <= 3'h5;
    tick();
    chk(cpuHalted, 1'b0);
    @(posedge clk);
    wakeIrqValid <= 1'b0;
    rchk(RST_CAUSE_ADDR, 32'h4, 32'h4);
    w(OSC_CLR_ADDR, 32'h00000010);
    pulse(0);
    chk({idleActive, sleepActive}, 2'h2);
    pulse(1);
    chk(cpuHalted, 1'b0);
    wr(8'h40, 32'h1, rsp);
    chk(rsp, RESP_SLVERR);
    rdr(8'h40, rd, rsp);
    chk(rsp, RESP_SLVERR);
    @(posedge clk);
    rstn <= 1'b0;
    {cfgPllOutputDivider, cfgPllMultiplier, cfgInitialSource} <= {3'h0, 3'h0, 3'h4};
    cfgBusDivisor <= 2'h0;
    cfgSecondaryOscEnable <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    rchk(OSC_CTRL_ADDR, 32'hFFFFFFFF, 32'h01004460);
    chk(pllMultiplyFactor, 5'h0F);
    results();
  end
endmodule
`default_nettype wire
